/* rtl/emf_frame_builder.v */
// Contract
// - frame carries selected signals; layout readable
// - raw/dark video: 512 samples, clip 4095
// - light-corrected video: 512 samples, full range
// - exposure word clamped 10..100000
// - intensity word clamped 0..1024
// - up to six signed distances per channel
// - frame counter counts frames, wraps 32 bits
// - symmetry fixed-point clamped +-32766
// - derived signal uses distance word rules
// - error range never holds valid distance
// - distance error codes 04..07 by condition
// - unrepresentable channel 1 distance gets unrep code; channel 2 never does
// - video block holds exactly one signal
// - video block may span several packets
// - video preamble is DATA
// - per peak: intensity then distance
// - settings change while running: error
// - start with empty selection: error
// - bytes sent least significant first
// - seven header words in fixed order
// - new header on content or rate change
`timescale 1ns/1ps
`include "emf_regs.vh"
module emf_frame_builder (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire        sample_i,
  input  wire        rate_chg_i,
  input  wire [31:0] shut1_i,
  input  wire [31:0] shut2_i,
  input  wire [31:0] enc1a_i,
  input  wire [31:0] enc1b_i,
  input  wire [31:0] enc2a_i,
  input  wire [31:0] enc2b_i,
  input  wire [31:0] int1_i,
  input  wire [31:0] int2_i,
  input  wire [31:0] sym1_i,
  input  wire [31:0] sym2_i,
  input  wire [31:0] comp_i,
  input  wire [1:0]  comp_err_i,
  input  wire [191:0] dist1_i,
  input  wire [191:0] dist2_i,
  input  wire [11:0] dist1_err_i,
  input  wire [11:0] dist2_err_i,
  input  wire [5:0]  dist_ovf_i,
  input  wire [15:0] vid_i,
  output wire        vid_req_o,
  output reg  [9:0]  vid_idx_o,
  output reg  [7:0]  byte_o,
  output reg         byte_valid_o,
  output reg         block_start_o,
  input  wire        byte_ready_i,
  output wire        running_o
);
  localparam S_IDLE = 3'h0;
  localparam S_HDR  = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_DATA = 3'h3;
  localparam S_VID  = 3'h4;

  reg [2:0]  state_ff;
  reg        run_ff;
  reg        err_act_ff;
  reg        err_emp_ff;
  reg [`EMF_SEL_W-1:0] sel_ff;
  reg [2:0]  peaks1_ff;
  reg [2:0]  peaks2_ff;
  reg [2:0]  vidsel_ff;
  reg        vid_mode_ff;
  reg [31:0] order_ff;
  reg [31:0] serial_ff;
  reg [31:0] count_ff;
  reg [31:0] proc_ff;
  reg        hdr_due_ff;
  reg [4:0]  widx_ff;
  reg [1:0]  bidx_ff;
  reg [31:0] word_ff;
  reg [31:0] snap_ff [0:31];
  reg [4:0]  nwords_ff;
  reg [31:0] nxt_word;
  integer    i;
  integer    j;
  integer    m;

  // clamp an unsigned word into a range
  function [31:0] clamp_u;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // distance word: error flags win over value
  function [31:0] dist_word;
    input [31:0] v;
    input [1:0]  e;
    input        ovf;
    begin
      if (e == 2'h1)
        dist_word = `EMF_ERR_NOPEAK;
      else if (e == 2'h2)
        dist_word = `EMF_ERR_BEFORE;
      else if (e == 2'h3)
        dist_word = `EMF_ERR_BEHIND;
      else if (ovf)
        dist_word = `EMF_ERR_UNREP;
      else if (v >= `EMF_ERR_LO && !v[31]) // negative distances stay valid
        dist_word = `EMF_ERR_NOCALC;
      else
        dist_word = v;
    end
  endfunction

  // signed symmetry clamp in fixed point
  function [31:0] clamp_sym;
    input [31:0] v;
    begin
      if ($signed(v) > $signed(`EMF_SYM_MAX))
        clamp_sym = `EMF_SYM_MAX;
      else if ($signed(v) < $signed(`EMF_SYM_MIN))
        clamp_sym = `EMF_SYM_MIN;
      else
        clamp_sym = v;
    end
  endfunction

  wire sel_empty = (sel_ff == {`EMF_SEL_W{1'b0}}) && !vid_mode_ff;
  wire start_wr  = wr_i && (addr_i == `EMF_ADDR_CTRL) && wdata_i[`EMF_CTRL_START];
  wire stop_wr   = wr_i && (addr_i == `EMF_ADDR_CTRL) && wdata_i[`EMF_CTRL_STOP];
  wire cfg_wr    = wr_i && (addr_i == `EMF_ADDR_SEL_LO || addr_i == `EMF_ADDR_SEL_HI ||
                   addr_i == `EMF_ADDR_PEAKS || addr_i == `EMF_ADDR_VIDSEL);
  wire beat      = byte_valid_o && byte_ready_i;
  assign running_o = run_ff;
  assign vid_req_o = (state_ff == S_VID);

  // register writes; settings locked while running
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run_ff      <= 1'b0;
      err_act_ff  <= 1'b0;
      err_emp_ff  <= 1'b0;
      sel_ff      <= {`EMF_SEL_W{1'b0}};
      peaks1_ff   <= 3'h1;
      peaks2_ff   <= 3'h1;
      vidsel_ff   <= 3'h0;
      vid_mode_ff <= 1'b0;
      order_ff    <= 32'h00000000;
      serial_ff   <= 32'h00000000;
    end
    else
    begin
      if (cfg_wr && run_ff)
        err_act_ff <= 1'b1;
      else if (cfg_wr)
      begin
        err_act_ff <= 1'b0;
        if (addr_i == `EMF_ADDR_SEL_LO)
          sel_ff <= wdata_i[`EMF_SEL_W-1:0];
        if (addr_i == `EMF_ADDR_PEAKS)
        begin
          peaks1_ff <= (wdata_i[2:0] > `EMF_MAX_PEAKS) ? `EMF_MAX_PEAKS : wdata_i[2:0];
          peaks2_ff <= (wdata_i[6:4] > `EMF_MAX_PEAKS) ? `EMF_MAX_PEAKS : wdata_i[6:4];
        end
        if (addr_i == `EMF_ADDR_VIDSEL)
        begin
          vidsel_ff   <= wdata_i[2:0]; // one video source only
          vid_mode_ff <= wdata_i[3];
        end
      end
      if (wr_i && addr_i == `EMF_ADDR_ORDER && !run_ff)
        order_ff <= wdata_i;
      if (wr_i && addr_i == `EMF_ADDR_SERIAL && !run_ff)
        serial_ff <= wdata_i;
      if (stop_wr)
        run_ff <= 1'b0;
      else if (start_wr && sel_empty)
        err_emp_ff <= 1'b1;
      else if (start_wr)
      begin
        run_ff     <= 1'b1;
        err_emp_ff <= 1'b0;
      end
    end
  end

  // number of scalar words in the frame
  reg [4:0] cnt_words;
  always @*
  begin
    cnt_words = 5'h0;
    for (j = 0; j < `EMF_SEL_W; j = j + 1)
      if (sel_ff[j] && j != `EMF_SEL_DIST1 && j != `EMF_SEL_DIST2 &&
          j != `EMF_SEL_INT1 && j != `EMF_SEL_INT2)
        cnt_words = cnt_words + 5'h1;
    if (sel_ff[`EMF_SEL_DIST1])
      cnt_words = cnt_words + {2'h0, peaks1_ff};
    if (sel_ff[`EMF_SEL_INT1])
      cnt_words = cnt_words + {2'h0, peaks1_ff};
    if (sel_ff[`EMF_SEL_DIST2])
      cnt_words = cnt_words + {2'h0, peaks2_ff};
    if (sel_ff[`EMF_SEL_INT2])
      cnt_words = cnt_words + {2'h0, peaks2_ff};
  end

  // header word mux, fixed order
  always @*
  begin
    case (widx_ff[2:0])
      3'h0: nxt_word = `EMF_PREAMBLE;
      3'h1: nxt_word = order_ff;
      3'h2: nxt_word = serial_ff;
      3'h3: nxt_word = vid_mode_ff ? {21'h0, `EMF_VID_SAMPLES, 1'b0} : 32'h0;
      3'h4: nxt_word = vid_mode_ff ? 32'h0 : {25'h0, nwords_ff, 2'h0};
      3'h5: nxt_word = 32'h00000001;
      default: nxt_word = proc_ff;
    endcase
  end

  // frame snapshot assembly in fixed internal order
  reg [31:0] asm_w [0:31];
  reg [4:0]  ap;
  reg [2:0]  pk;
  always @*
  begin
    ap = 5'h0;
    for (m = 0; m < 32; m = m + 1)
      asm_w[m] = 32'h0;
    if (sel_ff[`EMF_SEL_SHUT1])
    begin
      asm_w[ap] = clamp_u(shut1_i, `EMF_SHUT_MIN, `EMF_SHUT_MAX);
      ap = ap + 5'h1;
    end
    if (sel_ff[`EMF_SEL_ENC1A])
    begin
      asm_w[ap] = enc1a_i;
      ap = ap + 5'h1;
    end
    if (sel_ff[`EMF_SEL_ENC1B])
    begin
      asm_w[ap] = enc1b_i;
      ap = ap + 5'h1;
    end
    for (pk = 3'h0; pk < `EMF_MAX_PEAKS; pk = pk + 3'h1)
      if (pk < peaks1_ff)
      begin
        if (sel_ff[`EMF_SEL_INT1])
        begin
          asm_w[ap] = clamp_u(int1_i, 32'h0, `EMF_INT_MAX);
          ap = ap + 5'h1;
        end
        if (sel_ff[`EMF_SEL_DIST1])
        begin
          asm_w[ap] = dist_word(dist1_i[pk*32 +: 32], dist1_err_i[pk*2 +: 2], dist_ovf_i[pk]);
          ap = ap + 5'h1;
        end
      end
    if (sel_ff[`EMF_SEL_SHUT2])
    begin
      asm_w[ap] = clamp_u(shut2_i, `EMF_SHUT_MIN, `EMF_SHUT_MAX);
      ap = ap + 5'h1;
    end
    if (sel_ff[`EMF_SEL_ENC2A])
    begin
      asm_w[ap] = enc2a_i;
      ap = ap + 5'h1;
    end
    if (sel_ff[`EMF_SEL_ENC2B])
    begin
      asm_w[ap] = enc2b_i;
      ap = ap + 5'h1;
    end
    for (pk = 3'h0; pk < `EMF_MAX_PEAKS; pk = pk + 3'h1)
      if (pk < peaks2_ff)
      begin
        if (sel_ff[`EMF_SEL_INT2])
        begin
          asm_w[ap] = clamp_u(int2_i, 32'h0, `EMF_INT_MAX);
          ap = ap + 5'h1;
        end
        if (sel_ff[`EMF_SEL_DIST2])
        begin
          asm_w[ap] = dist_word(dist2_i[pk*32 +: 32], dist2_err_i[pk*2 +: 2], 1'b0);
          ap = ap + 5'h1;
        end
      end
    if (sel_ff[`EMF_SEL_COUNTER])
    begin
      asm_w[ap] = count_ff;
      ap = ap + 5'h1;
    end
    if (sel_ff[`EMF_SEL_SYM1])
    begin
      asm_w[ap] = clamp_sym(sym1_i);
      ap = ap + 5'h1;
    end
    if (sel_ff[`EMF_SEL_SYM2])
    begin
      asm_w[ap] = clamp_sym(sym2_i);
      ap = ap + 5'h1;
    end
    if (sel_ff[`EMF_SEL_COMP])
      asm_w[ap] = dist_word(comp_i, comp_err_i, 1'b0);
  end

  // video sample clip by source type
  wire [15:0] vid_word = (vidsel_ff[1:0] == 2'h2) ? vid_i :
                         ((vid_i > `EMF_VID_RAW_MAX) ? `EMF_VID_RAW_MAX : vid_i);

  // streaming state machine, lsb first
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff      <= S_IDLE;
      widx_ff       <= 5'h0;
      bidx_ff       <= 2'h0;
      word_ff       <= 32'h0;
      byte_o        <= 8'h00;
      byte_valid_o  <= 1'b0;
      block_start_o <= 1'b0;
      vid_idx_o     <= 10'h000;
      count_ff      <= 32'h0;
      proc_ff       <= 32'h0;
      hdr_due_ff    <= 1'b1;
      nwords_ff     <= 5'h0;
      for (i = 0; i < 32; i = i + 1)
        snap_ff[i] <= 32'h0;
    end
    else
    begin
      block_start_o <= 1'b0;
      if (sample_i)
        proc_ff <= proc_ff + 32'h1;
      case (state_ff)
        S_IDLE:
        begin
          byte_valid_o <= 1'b0;
          if (run_ff && sample_i)
          begin
            for (i = 0; i < 32; i = i + 1)
              snap_ff[i] <= asm_w[i];
            nwords_ff <= cnt_words;
            count_ff  <= count_ff + 32'h1;
            widx_ff   <= 5'h0;
            bidx_ff   <= 2'h0;
            if (hdr_due_ff || vid_mode_ff)
            begin
              state_ff      <= S_HDR; // video: fresh header each block
              block_start_o <= 1'b1;
              hdr_due_ff    <= 1'b0;
            end
            else
              state_ff <= S_WAIT;
          end
        end
        S_HDR, S_DATA:
        begin
          if (!byte_valid_o || beat)
          begin
            if (bidx_ff == 2'h0)
            begin
              byte_o       <= (state_ff == S_HDR) ? nxt_word[7:0] : snap_ff[widx_ff][7:0];
              word_ff      <= (state_ff == S_HDR) ? nxt_word : snap_ff[widx_ff];
              byte_valid_o <= 1'b1;
              bidx_ff      <= 2'h1;
            end
            else
            begin
              byte_o  <= word_ff[bidx_ff*8 +: 8];
              bidx_ff <= bidx_ff + 2'h1;
              if (bidx_ff == 2'h3)
              begin
                widx_ff <= widx_ff + 5'h1;
                if (state_ff == S_HDR && widx_ff[2:0] == `EMF_HDR_WORDS - 3'h1)
                begin
                  widx_ff  <= 5'h0;
                  state_ff <= vid_mode_ff ? S_VID : S_WAIT;
                end
                else if (state_ff == S_DATA && widx_ff == nwords_ff - 5'h1)
                  state_ff <= S_WAIT;
              end
            end
          end
        end
        S_WAIT:
        begin
          if (beat)
            byte_valid_o <= 1'b0;
          if (!byte_valid_o || beat)
          begin
            widx_ff  <= 5'h0;
            state_ff <= (nwords_ff == 5'h0 || !run_ff) ? S_IDLE :
                        ((state_ff == S_WAIT && widx_ff == 5'h0 && bidx_ff == 2'h0) ? S_DATA : S_IDLE);
            bidx_ff  <= 2'h0;
          end
        end
        S_VID:
        begin
          // one sample per two bytes; spans packets freely
          if (!byte_valid_o || beat)
          begin
            byte_valid_o <= 1'b1;
            byte_o       <= bidx_ff[0] ? vid_word[15:8] : vid_word[7:0];
            bidx_ff      <= {1'b0, ~bidx_ff[0]};
            if (bidx_ff[0])
            begin
              vid_idx_o <= vid_idx_o + 10'h001;
              if (vid_idx_o == `EMF_VID_SAMPLES - 10'h001)
              begin
                vid_idx_o <= 10'h000;
                bidx_ff   <= 2'h1;
                state_ff  <= S_WAIT;
                nwords_ff <= 5'h0;
              end
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
      // placed last so a change in the same cycle as a frame start still wins
      if (cfg_wr && !run_ff || rate_chg_i)
        hdr_due_ff <= 1'b1;
    end
  end

  // read port, data one cycle after strobe
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= 32'h0;
    else if (rd_i)
    begin
      case (addr_i)
        `EMF_ADDR_SEL_LO: rdata_o <= {{(32-`EMF_SEL_W){1'b0}}, sel_ff};
        `EMF_ADDR_STATUS: rdata_o <= {29'h0, err_emp_ff, err_act_ff, run_ff};
        `EMF_ADDR_ORDER:  rdata_o <= order_ff;
        `EMF_ADDR_SERIAL: rdata_o <= serial_ff;
        `EMF_ADDR_LAYOUT: rdata_o <= {{(32-`EMF_SEL_W){1'b0}}, sel_ff};
        `EMF_ADDR_WORDS:  rdata_o <= {27'h0, cnt_words};
        `EMF_ADDR_PEAKS:  rdata_o <= {25'h0, peaks2_ff, 1'b0, peaks1_ff};
        `EMF_ADDR_VIDSEL: rdata_o <= {28'h0, vid_mode_ff, vidsel_ff};
        default:          rdata_o <= 32'h0;
      endcase
    end
  end
endmodule

/* rtl/emf_regs.vh */
`ifndef EMF_REGS_VH
`define EMF_REGS_VH
// register offsets (word addresses on the plain port)
`define EMF_ADDR_CTRL      4'h0
`define EMF_ADDR_SEL_LO    4'h1
`define EMF_ADDR_SEL_HI    4'h2
`define EMF_ADDR_STATUS    4'h3
`define EMF_ADDR_ORDER     4'h4
`define EMF_ADDR_SERIAL    4'h5
`define EMF_ADDR_LAYOUT    4'h6
`define EMF_ADDR_WORDS     4'h7
`define EMF_ADDR_PEAKS     4'h8
`define EMF_ADDR_VIDSEL    4'h9
// ctrl bits
`define EMF_CTRL_START     0
`define EMF_CTRL_STOP      1
// status bits
`define EMF_ST_RUN         0
`define EMF_ST_ERR_ACTIVE  1
`define EMF_ST_ERR_EMPTY   2
// selection vector layout, fixed internal order
`define EMF_SEL_W          20
`define EMF_SEL_SHUT1      0
`define EMF_SEL_ENC1A      1
`define EMF_SEL_ENC1B      2
`define EMF_SEL_INT1       3
`define EMF_SEL_DIST1      4
`define EMF_SEL_SHUT2      5
`define EMF_SEL_ENC2A      6
`define EMF_SEL_ENC2B      7
`define EMF_SEL_INT2       8
`define EMF_SEL_DIST2      9
`define EMF_SEL_COUNTER    10
`define EMF_SEL_SYM1       11
`define EMF_SEL_SYM2       12
`define EMF_SEL_COMP       13
// constants
`define EMF_PREAMBLE       32'h41544144
`define EMF_VID_SAMPLES    10'h200
`define EMF_VID_RAW_MAX    16'h0FFF
`define EMF_SHUT_MIN       32'h0000000A
`define EMF_SHUT_MAX       32'h000186A0
`define EMF_INT_MAX        32'h00000400
`define EMF_SYM_MAX        32'h7FFE0000
`define EMF_SYM_MIN        32'h80020000
`define EMF_ERR_LO         32'h7FFFFF00
`define EMF_ERR_NOPEAK     32'h7FFFFF04
`define EMF_ERR_BEFORE     32'h7FFFFF05
`define EMF_ERR_BEHIND     32'h7FFFFF06
`define EMF_ERR_NOCALC     32'h7FFFFF07
`define EMF_ERR_UNREP      32'h07FFFF68
`define EMF_HDR_WORDS      3'h7
`define EMF_MAX_PEAKS      3'h6
`endif

/* test/emf_frame_builder_properties.sv */
`timescale 1ns/1ps
module emf_chk (
  input wire        clk_i,
  input wire        resetn_i,
  input wire [3:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [31:0] rdata_o,
  input wire        sample_i,
  input wire        vid_req_o,
  input wire [9:0]  vid_idx_o,
  input wire [7:0]  byte_o,
  input wire        byte_valid_o,
  input wire        block_start_o,
  input wire        byte_ready_i,
  input wire        running_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a block opens with the low preamble byte one cycle after its marker
  sequence s_hdr;
    block_start_o ##1 (byte_valid_o && byte_o == 8'h44);
  endsequence
  sequence s_stall;
    byte_valid_o && !byte_ready_i;
  endsequence
  sequence s_idle_sample;
    sample_i && running_o && !byte_valid_o && !block_start_o && !vid_req_o;
  endsequence
  AST_PREAMBLE: assert property (block_start_o |-> s_hdr)
    else $error("block not opened by preamble byte");
  AST_HOLD: assert property (s_stall |=> byte_valid_o && $stable(byte_o))
    else $error("byte changed while stalled");
  AST_HDR_CAUSE: assert property (block_start_o |-> $past(sample_i && running_o))
    else $error("header without a taken sample");
  AST_RUN_CAUSE: assert property ($rose(running_o) |-> $past(wr_i && addr_i == 4'h0 && wdata_i[0]))
    else $error("output started without start write");
  AST_STOP: assert property (wr_i && addr_i == 4'h0 && wdata_i[1] |=> !running_o)
    else $error("stop not honoured");
  AST_RDATA: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  AST_PULSE: assert property (block_start_o |=> !block_start_o)
    else $error("block marker longer than one cycle");
  AST_RESPOND: assert property (s_idle_sample |-> ##[1:4] (block_start_o || byte_valid_o))
    else $error("sample not turned into a frame");
  AST_VID_IDX: assert property (vid_req_o |-> vid_idx_o < 10'h200)
    else $error("video index beyond last sample");
endmodule
bind emf_frame_builder emf_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i), .vid_req_o(vid_req_o), .vid_idx_o(vid_idx_o),
  .byte_o(byte_o), .byte_valid_o(byte_valid_o), .block_start_o(block_start_o), .byte_ready_i(byte_ready_i),
  .running_o(running_o));

/* test/emf_sink.sv */
`timescale 1ns/1ps
module emf_sink (
  input  wire clk_i,
  input  wire resetn_i,
  input  wire slow_i,
  output reg  byte_ready_o
);
  integer      seed = 65662;
  reg   [31:0] r;
  // random stalls in slow mode, so every byte must hold while refused
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      byte_ready_o <= 1'b0;
    else
    begin
      r = $random(seed);
      byte_ready_o <= !slow_i || r[0];
    end
endmodule

/* test/tb_emf_frame_builder.sv */
`timescale 1ns/1ps
`include "emf_regs.vh"
module tb_emf_frame_builder;
  localparam [31:0] ORD = 32'h12345678; // arbitrary
  localparam [31:0] SER = 32'h0000ABCD; // arbitrary
  reg          clk_i = 1'b0;
  reg          resetn_i = 1'b0;
  reg  [3:0]   addr_i = 4'h0;
  reg  [31:0]  wdata_i = 32'h0;
  reg          wr_i = 1'b0;
  reg          rd_i = 1'b0;
  reg          sample_i = 1'b0;
  reg          rate_chg_i = 1'b0;
  reg  [31:0]  shut1_i = 32'h0;
  reg  [31:0]  int1_i = 32'h0;
  reg  [31:0]  rv = 32'h0;
  reg  [191:0] dist1_i = 192'h0;
  reg  [11:0]  dist1_err_i = 12'h0;
  reg  [5:0]   dist_ovf_i = 6'h0;
  reg          slow = 1'b0;
  wire [31:0]  rdata_o;
  wire [15:0]  vid_i;
  wire [9:0]   vid_idx_o;
  wire [7:0]   byte_o;
  wire         vid_req_o;
  wire         byte_valid_o;
  wire         block_start_o;
  wire         byte_ready_i;
  wire         running_o;
  integer      seed = 65662;
  integer      n_fail = 0;
  integer      n_tests = 0;
  integer      i;
  integer      k;
  integer      n;
  integer      s;
  reg  [8:0]   q[$];
  reg  [8:0]   e;
  reg  [31:0]  v;
  reg  [31:0]  d;

  always #25 clk_i = ~clk_i;
  // samples grow with the index, so clipping shows from index 64 on
  assign vid_i = {vid_idx_o, 6'h2A};

  emf_frame_builder dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i), .rate_chg_i(rate_chg_i), .shut1_i(shut1_i),
    .shut2_i(rv), .enc1a_i(rv), .enc1b_i(~rv), .enc2a_i(rv), .enc2b_i(rv), .int1_i(int1_i), .int2_i(rv),
    .sym1_i(rv), .sym2_i(rv), .comp_i(rv), .comp_err_i(rv[1:0]), .dist1_i(dist1_i), .dist2_i({6{rv}}),
    .dist1_err_i(dist1_err_i), .dist2_err_i(rv[11:0]), .dist_ovf_i(dist_ovf_i), .vid_i(vid_i),
    .vid_req_o(vid_req_o), .vid_idx_o(vid_idx_o), .byte_o(byte_o), .byte_valid_o(byte_valid_o),
    .block_start_o(block_start_o), .byte_ready_i(byte_ready_i), .running_o(running_o));
  emf_sink sink (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow), .byte_ready_o(byte_ready_i));

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  task wr(input [3:0] a, input [31:0] dat);
    begin
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= dat;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
    end
  endtask

  // read data is taken just after the edge where it lands
  task rd(input [3:0] a, output [31:0] dat);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 dat = rdata_o;
    end
  endtask

  // note a word as four bytes, low byte first; x marks a free value
  task pw(input [31:0] w, input x);
    for (k = 0; k < 4; k = k + 1)
      q.push_back({x, w[8*k +: 8]});
  endtask

  task hdr(input [31:0] vl, input [31:0] ml);
    begin
      pw(`EMF_PREAMBLE, 1'b0);
      pw(ORD, 1'b0);
      pw(SER, 1'b0);
      pw(vl, 1'b0);
      pw(ml, 1'b0);
      pw(32'h1, 1'b0);
      pw(32'h0, 1'b1);
    end
  endtask

  // one sample pulse, then wait until every noted byte has come out
  task fire;
    begin
      @(posedge clk_i);
      sample_i <= 1'b1;
      @(posedge clk_i);
      sample_i <= 1'b0;
      i = 0;
      while (q.size() != 0 && i < 4000)
      begin
        @(posedge clk_i);
        i = i + 1;
      end
      chk(q.size(), 32'h0);
      repeat (4) @(posedge clk_i);
    end
  endtask

  task frm(input h, input [31:0] si, input [31:0] se, input [31:0] ii, input [31:0] ie, input [31:0] d0,
           input [31:0] d1, input [11:0] er, input [5:0] ov, input [31:0] e0, input [31:0] e1);
    begin
      if (h)
        hdr(32'h0, 32'h18);
      pw(se, 1'b0);
      pw(ie, 1'b0);
      pw(e0, 1'b0);
      pw(ie, 1'b0);
      pw(e1, 1'b0);
      pw(32'h0, 1'b1);
      shut1_i <= si;
      int1_i <= ii;
      dist1_i <= {128'h0, d1, d0};
      dist1_err_i <= er;
      dist_ovf_i <= ov;
      rv <= $random(seed);
      fire;
    end
  endtask

  // stream watcher: every accepted byte against the oldest note
  always @(posedge clk_i)
    if (resetn_i && byte_valid_o === 1'b1 && byte_ready_i === 1'b1)
    begin
      if (q.size() == 0)
        chk(32'h1, 32'h0);
      else
      begin
        e = q.pop_front();
        if (!e[8])
          chk({24'h0, byte_o}, {24'h0, e[7:0]});
      end
    end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail = n_fail + 1;
    results;
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`EMF_ADDR_PEAKS, v);
    chk(v, 32'h11);
    wr(`EMF_ADDR_CTRL, 32'h1);
    rd(`EMF_ADDR_STATUS, v);
    chk(v, 32'h4);
    wr(`EMF_ADDR_SEL_LO, 32'h419);
    wr(`EMF_ADDR_PEAKS, 32'h12);
    wr(`EMF_ADDR_ORDER, ORD);
    wr(`EMF_ADDR_SERIAL, SER);
    rd(`EMF_ADDR_LAYOUT, v);
    chk(v, 32'h419);
    rd(`EMF_ADDR_WORDS, v);
    chk(v, 32'h6);
    wr(`EMF_ADDR_CTRL, 32'h1);
    rd(`EMF_ADDR_STATUS, v);
    chk(v, 32'h1);
    d = $random(seed) & 32'hBFFFFFFF;
    frm(1'b1, 32'h5, 32'hA, 32'h7D0, 32'h400, d, d, 12'h004, 6'h0, d, `EMF_ERR_NOPEAK);
    frm(1'b0, 32'h30D40, 32'h186A0, 32'h1F4, 32'h1F4, d, 32'h7FFFFF10, 12'h0, 6'h01,
        `EMF_ERR_UNREP, `EMF_ERR_NOCALC);
    @(posedge clk_i);
    rate_chg_i <= 1'b1;
    @(posedge clk_i);
    rate_chg_i <= 1'b0;
    frm(1'b1, 32'h32, 32'h32, 32'h400, 32'h400, d, d, 12'h00E, 6'h0, `EMF_ERR_BEFORE, `EMF_ERR_BEHIND);
    wr(`EMF_ADDR_SEL_LO, 32'h1);
    rd(`EMF_ADDR_STATUS, v);
    chk(v, 32'h3);
    rd(`EMF_ADDR_LAYOUT, v);
    chk(v, 32'h419);
    wr(`EMF_ADDR_CTRL, 32'h3);
    rd(`EMF_ADDR_STATUS, v);
    chk({31'h0, v[0]}, 32'h0);
    slow <= 1'b1;
    // one video signal per block, each asked for on its own
    for (s = 0; s < 3; s = s + 1)
    begin
      wr(`EMF_ADDR_SEL_LO, 32'h0);
      wr(`EMF_ADDR_VIDSEL, 32'h8 | s);
      wr(`EMF_ADDR_CTRL, 32'h1);
      hdr(32'h400, 32'h0);
      for (n = 0; n < 512; n = n + 1)
      begin
        v = {16'h0, n[9:0], 6'h2A};
        if (s != 2 && v > 32'hFFF)
          v = 32'hFFF;
        q.push_back({1'b0, v[7:0]});
        q.push_back({1'b0, v[15:8]});
      end
      fire;
      wr(`EMF_ADDR_CTRL, 32'h2);
    end
    results;
  end
endmodule
